// ### logic/instr_decoder_consts.vh
`ifndef INSTR_DECODER_CONSTS_VH
`define INSTR_DECODER_CONSTS_VH
// instruction word geometry
`define IW_WIDTH 16
`define OPND_EXT_PREFIX 4'hF
// oscillator periods per instruction cycle
`define OSC_PER_CYCLE 4
`define QPHASE_LAST 2'h3
// instruction set sizes
`define STD_INSTR_COUNT 75
`define EXT_INSTR_COUNT 8
// field positions
`define F_ADDR_MSB 7
`define D_BIT 9
`define A_BIT 8
`define BIT_NUM_MSB 11
`define BIT_NUM_LSB 9
`define S_BIT 0
`define TBL_MODE_MSB 1
// class codes
`define CLS_BYTE 4'h1
`define CLS_BIT 4'h2
`define CLS_LIT 4'h4
`define CLS_CTRL 4'h8
// table pointer modes
`define TBL_NOCHG 2'h0
`define TBL_POSTINC 2'h1
`define TBL_POSTDEC 2'h2
`define TBL_PREINC 2'h3
`endif

// ### logic/instr_decoder.v
`timescale 1ns/1ps
`default_nettype none
`include "instr_decoder_consts.vh"

// Contract
// - 75 standard plus 8 extended instructions
// - 16-bit words; four instructions use two
// - second word top nibble all ones
// - lone second word executes as NOP
// - one cycle; two if skip or branch
// - two-word instructions take two cycles
// - instruction cycle is four oscillator periods
// - taken two-word branch takes three cycles
// - byte ops decode file, destination, access
// - destination zero to accumulator, one to file
// - bit ops decode file, bit number, access
// - literals decode constant and pointer select
// - control decodes address, fast bit, table mode
// - access zero uses access bank, ignores selector
// - bit number three bits selects 0..7
// - fast bit set saves/restores shadow registers
// - table mode: none, postinc, postdec, preinc
module instr_decoder (
  input wire clk_sys, // 250 MHz core clock
  input wire rst_n, // synchronous reset, active low
  input wire [15:0] fetch_word, // fetched program word, same domain
  input wire fetch_valid, // word presented this instruction cycle
  input wire cond_true, // skip test or branch condition met
  input wire ext_enable, // extended set enabled (level)
  output reg [3:0] instr_class, // one-hot class of current word
  output reg [7:0] file_addr, // file register address
  output reg dest_to_file, // 1: result to file, 0: accumulator
  output reg use_bank_selector, // 1: bank_selector picks the bank
  output reg use_access_bank, // 1: fixed access bank
  output reg [2:0] bit_num, // selected bit of file register
  output reg [7:0] literal, // literal operand
  output reg [1:0] ptr_select, // indirect_pointer_register index
  output reg [19:0] branch_addr, // absolute or relative target field
  output reg fast_mode, // shadow register save/restore
  output reg [1:0] table_mode, // table_pointer update mode
  output reg two_word_first, // first word of two-word instruction
  output reg operand_word, // word consumed as operand extension
  output reg is_nop, // word executes as no-operation
  output reg ext_instr, // decoded from extended set
  output reg [1:0] exec_cycles, // instruction cycles this instruction
  output reg cycle_tick, // pulse once per instruction cycle
  output reg [1:0] q_phase // oscillator phase within cycle
);

  // ======================================
  // instruction cycle timing
  // ======================================
  reg [1:0] next_q_phase;
  wire cyc_end;
  assign cyc_end = (q_phase == `QPHASE_LAST);

  // one instruction cycle spans four clocks
  always @* begin
    next_q_phase = q_phase + 2'h1;
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      q_phase <= 2'h0;
      cycle_tick <= 1'b0;
    end else begin
      q_phase <= next_q_phase;
      cycle_tick <= cyc_end;
    end
  end

  // ======================================
  // classification
  // ======================================
  reg [3:0] next_class;
  reg next_two_first;
  reg next_is_ext;
  reg next_is_branch;
  reg next_pc_change;
  reg next_skip_type;
  wire [3:0] top;
  wire is_ext_word;
  assign top = fetch_word[15:12];
  // a word with all-ones prefix after a two-word first word is operand data
  assign is_ext_word = (top == `OPND_EXT_PREFIX);

  // class chosen before fields are extracted; opcode groups by top bits
  always @* begin
    next_class = `CLS_CTRL;
    next_two_first = 1'b0;
    next_is_ext = 1'b0;
    next_is_branch = 1'b0;
    next_pc_change = 1'b0;
    next_skip_type = 1'b0;
    if (top >= 4'h7 && top <= 4'hB) begin
      next_class = `CLS_BIT;
      next_skip_type = (top == 4'hA) || (top == 4'hB);
    end else if (top == 4'h0 && fetch_word[11:8] >= 4'h8) begin
      next_class = `CLS_LIT;
    end else if (top == 4'h0) begin
      next_class = `CLS_CTRL;
      // stack returns and pops move the pc; other low words do not
      case (fetch_word[11:0])
        12'h010: next_pc_change = 1'b1;
        12'h011: next_pc_change = 1'b1;
        12'h012: next_pc_change = 1'b1;
        12'h013: next_pc_change = 1'b1;
        default: next_pc_change = 1'b0;
      endcase
    end else if (top == 4'hC) begin
      next_class = `CLS_BYTE; // move file to file, two words
      next_two_first = 1'b1;
    end else if (top == 4'hD || top == 4'hE) begin
      next_class = `CLS_CTRL;
      next_pc_change = 1'b1;
      next_is_branch = 1'b1;
      if (fetch_word[11:9] == 3'h6 || fetch_word[11:8] == 4'hF) begin
        next_two_first = 1'b1; // call and goto
      end
      if (top == 4'hE && fetch_word[11:8] == 4'hE) begin
        next_class = `CLS_LIT; // load pointer, two words
        next_pc_change = 1'b0;
        next_is_branch = 1'b0;
        next_two_first = 1'b1;
      end
      if (top == 4'hE && fetch_word[11:8] == 4'h8) begin
        next_is_ext = 1'b1; // extended literal ops
        next_pc_change = 1'b0;
        next_is_branch = 1'b0;
        next_class = `CLS_LIT;
      end
    end else begin
      next_class = `CLS_BYTE;
      next_skip_type = (top == 4'h6);
    end
  end

  // ======================================
  // decode sequencer
  // ======================================
  localparam ST_FIRST = 2'b01;
  localparam ST_OPERAND = 2'b10;
  reg [1:0] state;
  reg [1:0] next_state;
  reg pend_branch;

  // a two-word first word arriving in place of an operand word starts a new pair
  always @* begin
    case (state)
      ST_FIRST: begin
        next_state = (next_two_first && fetch_valid) ? ST_OPERAND : ST_FIRST;
      end
      ST_OPERAND: begin
        if (!fetch_valid) begin
          next_state = ST_OPERAND;
        end else if (!is_ext_word && next_two_first) begin
          next_state = ST_OPERAND;
        end else begin
          next_state = ST_FIRST;
        end
      end
      default: begin
        next_state = ST_FIRST;
      end
    endcase
  end

  // sequencer moves only when a word is taken
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= ST_FIRST;
    end else if (take_word) begin
      state <= next_state;
    end
  end

  // ======================================
  // decode strobes
  // ======================================
  wire take_word; // word accepted at this edge
  wire take_operand; // extension word completing a pair
  wire take_stray; // extension word with no two-word first word before it
  wire take_first; // any other word starts an instruction
  reg [1:0] next_exec_cycles;

  // only the last phase with valid high takes a word; others are ignored
  assign take_word = cyc_end && fetch_valid;
  assign take_operand = take_word && (state == ST_OPERAND) && is_ext_word;
  assign take_stray = take_word && (state != ST_OPERAND) && is_ext_word;
  assign take_first = take_word && !is_ext_word;

  // cycles of a first word; a pair is settled again by its operand
  always @* begin
    if (next_two_first) begin
      next_exec_cycles = 2'h2;
    end else if (next_pc_change || (next_skip_type && cond_true)) begin
      next_exec_cycles = 2'h2;
    end else begin
      next_exec_cycles = 2'h1;
    end
  end

  // ======================================
  // class and pairing flags
  // ======================================
  // flags hold between taken words so the core may read them any time
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      instr_class <= `CLS_CTRL;
      two_word_first <= 1'b0;
      operand_word <= 1'b0;
      is_nop <= 1'b1;
      ext_instr <= 1'b0;
      pend_branch <= 1'b0;
    end else if (take_operand) begin
      // class of the held first word stays in force
      operand_word <= 1'b1;
      two_word_first <= 1'b0;
      is_nop <= 1'b0;
    end else if (take_stray) begin
      // stray operand word runs alone, no side effects
      instr_class <= `CLS_CTRL;
      operand_word <= 1'b0;
      two_word_first <= 1'b0;
      is_nop <= 1'b1;
    end else if (take_first) begin
      instr_class <= next_class;
      two_word_first <= next_two_first;
      operand_word <= 1'b0;
      is_nop <= (fetch_word == 16'h0000);
      // extended ops decode as such only while the set is enabled
      ext_instr <= next_is_ext && ext_enable;
      pend_branch <= next_is_branch;
    end
  end

  // ======================================
  // data operand fields
  // ======================================
  // fields are cut from every first word; the class says which matter
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      file_addr <= 8'h00;
      dest_to_file <= 1'b0;
      use_bank_selector <= 1'b0;
      use_access_bank <= 1'b1;
      bit_num <= 3'h0;
      literal <= 8'h00;
      ptr_select <= 2'h0;
    end else if (take_first) begin
      file_addr <= fetch_word[`F_ADDR_MSB:0];
      dest_to_file <= fetch_word[`D_BIT];
      use_bank_selector <= fetch_word[`A_BIT];
      use_access_bank <= ~fetch_word[`A_BIT];
      bit_num <= fetch_word[`BIT_NUM_MSB:`BIT_NUM_LSB];
      literal <= fetch_word[7:0];
      ptr_select <= fetch_word[5:4];
    end
  end

  // ======================================
  // control operand fields and timing
  // ======================================
  // the operand word supplies the upper target bits of a pair
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      branch_addr <= 20'h00000;
      fast_mode <= 1'b0;
      table_mode <= `TBL_NOCHG;
      exec_cycles <= 2'h1;
    end else if (take_operand) begin
      branch_addr <= {fetch_word[11:0], branch_addr[7:0]};
      // two cycles, three when a two-word branch is taken
      exec_cycles <= (pend_branch && cond_true) ? 2'h3 : 2'h2;
    end else if (take_stray) begin
      // a lone extension word must not touch shadow or table state
      fast_mode <= 1'b0;
      table_mode <= `TBL_NOCHG;
      exec_cycles <= 2'h1;
    end else if (take_first) begin
      branch_addr <= {12'h000, fetch_word[7:0]};
      // fast bit only meaningful for call and return
      fast_mode <= next_is_branch ? fetch_word[8] : fetch_word[`S_BIT];
      table_mode <= fetch_word[`TBL_MODE_MSB:0];
      exec_cycles <= next_exec_cycles;
    end
  end

endmodule
`default_nettype wire

// ### tb/instr_decoder_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "instr_decoder_consts.vh"
// ==========
// decoder port checker
module instr_decoder_monitor (
  input wire logic clk_sys, // core clock
  input wire logic rst_n, // sync reset
  input wire logic [15:0] fetch_word, // word in
  input wire logic fetch_valid, // word present
  input wire logic [3:0] instr_class, // class
  input wire logic [7:0] file_addr, // file address
  input wire logic use_bank_selector, // bank via selector
  input wire logic use_access_bank, // access bank
  input wire logic [2:0] bit_num, // bit number
  input wire logic [19:0] branch_addr, // target
  input wire logic two_word_first, // first of pair
  input wire logic operand_word, // operand word
  input wire logic is_nop, // nop
  input wire logic [1:0] exec_cycles, // cycles
  input wire logic cycle_tick, // tick
  input wire logic [1:0] q_phase // phase
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // word accepted, then word with the extension prefix
  sequence taken;
    q_phase == `QPHASE_LAST && fetch_valid;
  endsequence
  sequence ext_word;
    taken ##0 fetch_word[15:12] == `OPND_EXT_PREFIX;
  endsequence
  sequence bit_word;
    taken ##0 fetch_word[15:12] inside {[4'h7:4'hB]};
  endsequence
  a_phase_step: assert property ($past(rst_n) |-> q_phase == $past(q_phase) + 2'h1)
    else $error("phase did not advance");
  a_tick_after_q3: assert property (q_phase == `QPHASE_LAST |=> cycle_tick ##1 !cycle_tick [*3])
    else $error("tick not once per four clocks");
  a_bit_fields: assert property (bit_word |=> instr_class == `CLS_BIT && bit_num == $past(fetch_word[11:9]) && file_addr == $past(fetch_word[7:0]))
    else $error("bit operand fields wrong");
  a_bank_pick: assert property (bit_word |=> use_bank_selector == $past(fetch_word[8]) && use_access_bank == !$past(fetch_word[8]))
    else $error("bank choice wrong");
  a_lone_nop: assert property (ext_word ##0 !two_word_first |=> is_nop && exec_cycles == 2'h1 && !operand_word)
    else $error("lone extension not a nop");
  a_pair_operand: assert property (ext_word ##0 two_word_first |=> operand_word && exec_cycles >= 2'h2 && branch_addr[19:8] == $past(fetch_word[11:0]))
    else $error("second word not consumed");
  a_decode_holds: assert property (q_phase != `QPHASE_LAST |=> $stable(instr_class) && $stable(file_addr) && $stable(branch_addr))
    else $error("decode changed mid cycle");
  a_refused_word: assert property (q_phase == `QPHASE_LAST && !fetch_valid |=> $stable(instr_class) && $stable(exec_cycles))
    else $error("absent word changed decode");
endmodule
bind instr_decoder instr_decoder_monitor mon (.*);
`default_nettype wire

// ### tb/fetch_path_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// program fetch path: released bus shows the inverse of the last word
module fetch_path_model (
  input wire logic clk_sys, // core clock
  input wire logic [15:0] next_word, // word to offer
  input wire logic next_valid, // offer now
  output logic [15:0] fetch_word, // to decoder
  output logic fetch_valid // to decoder
);
  logic [15:0] last = 16'h0000;
  assign fetch_word = next_valid ? next_word : ~last;
  assign fetch_valid = next_valid;
  // remember what was last offered
  always @(posedge clk_sys) if (next_valid) last <= next_word;
endmodule
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "instr_decoder_consts.vh"
// ==========
// decoder bench
module testbench;
  logic clk_sys = 1'b0, rst_n = 1'b0, cond_true = 1'b0, ext_enable = 1'b0, next_valid = 1'b0;
  logic [15:0] next_word = 16'h0000, fetch_word;
  logic [7:0] file_addr, literal;
  logic [3:0] instr_class;
  logic [2:0] bit_num;
  logic [1:0] ptr_select, table_mode, exec_cycles, q_phase;
  logic [19:0] branch_addr;
  logic fetch_valid, dest_to_file, use_bank_selector, use_access_bank, fast_mode, two_word_first;
  logic operand_word, is_nop, ext_instr, cycle_tick;
  int bad_count = 0, checks = 0;
  fetch_path_model fpm (.clk_sys(clk_sys), .next_word(next_word), .next_valid(next_valid),
    .fetch_word(fetch_word), .fetch_valid(fetch_valid));
  instr_decoder dut (.*);
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  task chk(input logic [19:0] seen, input logic [19:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // offer one word in the phase-3 cycle, judge in the cycle after
  task take(input logic [15:0] w, input logic c);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (q_phase !== 2'h3 && n < 8) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 8) begin
      bad_count++;
      close_out;
    end
    next_word = w;
    next_valid = 1'b1;
    cond_true = c;
    @(negedge clk_sys);
    next_valid = 1'b0;
    chk(cycle_tick, 1'h1);
  endtask
  task t_reset;
    chk(instr_class, `CLS_CTRL); chk(is_nop, 1'h1);
    chk(use_access_bank, 1'h1); chk(exec_cycles, 2'h1);
  endtask
  task t_byte;
    take(16'h2655, 1'h0); chk(instr_class, `CLS_BYTE); chk(file_addr, 8'h55);
    chk(dest_to_file, 1'h1); chk(use_access_bank, 1'h1);
    chk(exec_cycles, 2'h1);
    take(16'h2555, 1'h0); chk(dest_to_file, 1'h0); chk(use_bank_selector, 1'h1);
  endtask
  task t_bits;
    for (int b = 0; b < 8; b++) begin
      take(16'h70A5 | 16'(b << 9), 1'h0); chk(bit_num, b[2:0]);
    end
  endtask
  task t_pairs;
    take(16'hF123, 1'h0); chk(is_nop, 1'h1); chk(exec_cycles, 2'h1);
    take(16'hEC12, 1'h0); chk(two_word_first, 1'h1);
    take(16'hF567, 1'h0); chk(operand_word, 1'h1); chk(exec_cycles, 2'h2);
    chk(branch_addr, 20'h56712);
    take(16'hEF34, 1'h0); take(16'hF9AB, 1'h1); chk(exec_cycles, 2'h3);
  endtask
  task t_ctrl;
    for (int m = 0; m < 4; m++) begin
      take(16'h0008 + 16'(m), 1'h0); chk(table_mode, m[1:0]);
    end
    take(16'h0012, 1'h0); chk(fast_mode, 1'h0); chk(exec_cycles, 2'h2);
    take(16'h0013, 1'h0); chk(fast_mode, 1'h1);
    take(16'h0E3C, 1'h0); chk(instr_class, `CLS_LIT); chk(literal, 8'h3C);
  endtask
  task t_ext;
    ext_enable = 1'b1;
    take(16'hE812, 1'h0); chk(ext_instr, 1'h1);
    ext_enable = 1'b0;
    take(16'hE812, 1'h0); chk(ext_instr, 1'h0);
    take(16'hEE25, 1'h0); chk(ptr_select, 2'h2); chk(exec_cycles, 2'h2);
    take(16'hF0AB, 1'h0); chk(operand_word, 1'h1); chk(exec_cycles, 2'h2);
  endtask
  // reset for four cycles, then the scenarios in turn
  initial begin
    repeat (4) @(negedge clk_sys);
    t_reset;
    rst_n = 1'b1;
    t_byte;
    t_bits;
    t_pairs;
    t_ctrl;
    t_ext;
    close_out;
  end
endmodule
`default_nettype wire
